/* File: src/supervisor_pkg.sv */
// Shared constants, pin bundles and state codes of the reset supervisor.
// Assumes a single 40 MHz clock; all long times are counted in timebase ticks.
package supervisor_pkg;

  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_NS      = 1_000_000;
  localparam int unsigned TICK_CYCLES  = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned NS_PER_MS    = 1_000_000;

  localparam int unsigned HOLD_MS      = 250;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned WD_SHORT_MS  = 150;
  localparam int unsigned WD_MID_MS    = 600;
  localparam int unsigned WD_LONG_MS   = 1200;

  localparam int unsigned CNT_W = 11;
  typedef logic [CNT_W-1:0] tick_cnt_t;

  // A minimum time gains one tick because the first tick may come at once
  localparam tick_cnt_t HOLD_TICKS  = tick_cnt_t'(HOLD_MS * NS_PER_MS / TICK_NS + 1);
  localparam tick_cnt_t DEB_TICKS   = tick_cnt_t'(DEBOUNCE_MS * NS_PER_MS / TICK_NS + 1);
  localparam tick_cnt_t WD_SHORT_TK = tick_cnt_t'(WD_SHORT_MS * NS_PER_MS / TICK_NS);
  localparam tick_cnt_t WD_MID_TK   = tick_cnt_t'(WD_MID_MS * NS_PER_MS / TICK_NS);
  localparam tick_cnt_t WD_LONG_TK  = tick_cnt_t'(WD_LONG_MS * NS_PER_MS / TICK_NS);
  localparam tick_cnt_t CNT_ZERO    = tick_cnt_t'(0);
  localparam tick_cnt_t CNT_ONE     = tick_cnt_t'(1);

  // Three-level strap seen as two digital bits
  typedef enum logic [1:0] {
    STRAP_LOW  = 2'b00,
    STRAP_OPEN = 2'b01,
    STRAP_HIGH = 2'b10
  } wd_strap_t;

  typedef struct packed {
    logic      supply_fail_5;
    logic      supply_fail_10;
    logic      pushbutton_reset_n;
    logic      watchdog_strobe_n;
    logic      tolerance_select;
    wd_strap_t timeout_select;
    logic      reset_n_i;
  } pin_in_t;

  localparam pin_in_t PIN_IDLE = 8'h33;

  typedef struct packed {
    logic active_high;
    logic low_o;
    logic low_oe_n;
  } reset_out_t;

  typedef enum logic {
    S_HOLD = 1'b0,
    S_RUN  = 1'b1
  } sup_state_t;

endpackage

/* File: src/pin_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes every bit is a slow level; no bit is read between the two flops.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned    WIDTH    = 8,
  parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= IDLE_VAL;
      sync_out <= IDLE_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: src/reset_supervisor_watchdog.sv */
// Reset supervisor: supply fault, debounced pushbutton and watchdog drive two reset outputs.
// Assumes asynchronous pins, one 40 MHz clock, comparator results as digital inputs.
//
// How it works
// R1: Selected supply fault asserts both reset outputs at once.
// R2: After the fault clears, reset stays asserted at least 250 ms.
// R3: Pushbutton is debounced; each accepted press gives a reset of 250 ms minimum.
// R4: Watchdog expiry without a strobe asserts both reset outputs.
// R5: Three watchdog periods are offered: about 150 ms, 600 ms, 1.2 s.
// R6: Tolerance select picks the 5% or the 10% supply fault indication.
// R7: One reset output is high while reset is asserted, low otherwise.
// R8: Complementary open-drain output pulls low during reset, released otherwise.
// R9: Timeout select low gives 150 ms, open 600 ms, high 1.2 s.
// R10: Each falling strobe edge restarts the full watchdog period.
// R11: Watchdog counts only once both reset outputs are inactive.
// R12: Pushbutton hold time is measured from the button's release.
// R13: All times come from one free-running tick; counters restart under reset.
`timescale 1ns/1ps
module reset_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic    clk,
  input  wire logic    arst_n,
  input  wire pin_in_t pins,
  output reset_out_t   rst_out,
  output logic         reset_line_low
);

  localparam int unsigned PRE_W = $clog2(TICK_LEN + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_LEN - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = PRE_W'(0);
  localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);

  function automatic tick_cnt_t wd_limit_of(input wd_strap_t sel);
    tick_cnt_t lim;
    lim = WD_MID_TK;
    unique case (sel)
      STRAP_LOW:  lim = WD_SHORT_TK;
      STRAP_HIGH: lim = WD_LONG_TK;
      default: lim = WD_MID_TK;
    endcase
    return lim;
  endfunction

  pin_in_t    pins_s;
  logic [PRE_W-1:0] pre_q;
  logic       tick;
  logic       pfail;
  logic       pb_stable_q;
  tick_cnt_t  deb_cnt_q;
  logic       strobe_prev_q;
  logic       strobe_fall;
  logic       cause;
  sup_state_t state_q;
  tick_cnt_t  hold_cnt_q;
  tick_cnt_t  wd_cnt_q;
  tick_cnt_t  wd_limit;
  logic       wd_expire;
  logic       reset_on;

  pin_sync #(
    .WIDTH    ($bits(pin_in_t)),
    .IDLE_VAL (PIN_IDLE)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (pins),
    .sync_out (pins_s)
  );

  // Free-running timebase; a tick is a one-cycle enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= PRE_ZERO;
    end else if (pre_q == PRE_LAST) begin
      pre_q <= PRE_ZERO;
    end else begin
      pre_q <= pre_q + PRE_ONE;
    end
  end
  assign tick = (pre_q == PRE_LAST); // [R13]

  // Comparator result chosen by the tolerance strap
  assign pfail = pins_s.tolerance_select ? pins_s.supply_fail_10
                                         : pins_s.supply_fail_5; // [R6]

  // Debounce both edges; a level must stand for the whole window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pb_stable_q <= 1'b1;
      deb_cnt_q   <= CNT_ZERO;
    end else if (pins_s.pushbutton_reset_n == pb_stable_q) begin
      deb_cnt_q <= CNT_ZERO;
    end else if (deb_cnt_q == DEB_TICKS) begin
      pb_stable_q <= pins_s.pushbutton_reset_n; // [R3]
      deb_cnt_q   <= CNT_ZERO;
    end else if (tick) begin
      deb_cnt_q <= deb_cnt_q + CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= pins_s.watchdog_strobe_n;
    end
  end
  assign strobe_fall = strobe_prev_q && !pins_s.watchdog_strobe_n; // [R10]

  // While the button is held the hold count stays at zero, so it runs from release
  assign cause = pfail || !pb_stable_q; // [R1] [R12]

  assign wd_limit  = wd_limit_of(pins_s.timeout_select); // [R5] [R9]
  assign wd_expire = (state_q == S_RUN) && (wd_cnt_q >= wd_limit) && !strobe_fall; // [R4]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_HOLD;
    end else begin
      unique case (state_q)
        S_HOLD: begin
          if (!cause && hold_cnt_q == HOLD_TICKS) begin
            state_q <= S_RUN; // [R2]
          end
        end
        S_RUN: begin
          if (cause || wd_expire) begin
            state_q <= S_HOLD; // [R1] [R3] [R4]
          end
        end
      endcase
    end
  end

  // Hold counter restarts whenever a cause is present or reset is entered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_q <= CNT_ZERO;
    end else if (state_q == S_RUN || cause) begin
      hold_cnt_q <= CNT_ZERO; // [R13] [R12]
    end else if (tick && hold_cnt_q != HOLD_TICKS) begin
      hold_cnt_q <= hold_cnt_q + CNT_ONE; // [R2]
    end
  end

  // Strobe edge beats a coincident tick so a late strobe is never lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_q <= CNT_ZERO;
    end else if (state_q == S_HOLD || strobe_fall) begin
      wd_cnt_q <= CNT_ZERO; // [R11] [R10]
    end else if (tick && wd_cnt_q < wd_limit) begin
      wd_cnt_q <= wd_cnt_q + CNT_ONE; // [R4]
    end
  end

  assign reset_on = (state_q == S_HOLD);
  // One driver for the whole bundle keeps the output a single-driver variable
  assign rst_out = '{
    active_high: reset_on,  // [R7]
    low_o:       1'b0,      // [R8]
    low_oe_n:    !reset_on  // [R8]
  };

  // Other devices may also pull the shared reset line low
  assign reset_line_low = !pins_s.reset_n_i;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_pfail_reset;
    pfail |=> rst_out.active_high && !rst_out.low_oe_n;
  endproperty
  a_pfail_reset: assert property (p_pfail_reset) // [R1]
    else $error("supply fault did not assert reset");

  property p_hold_min;
    $fell(rst_out.active_high) |-> $past(hold_cnt_q) == HOLD_TICKS && !$past(cause);
  endproperty
  a_hold_min: assert property (p_hold_min) // [R2]
    else $error("reset released before hold time");

  property p_press_reset;
    $fell(pb_stable_q) |=> rst_out.active_high ##1 hold_cnt_q == CNT_ZERO;
  endproperty
  a_press_reset: assert property (p_press_reset) // [R3]
    else $error("accepted press did not give reset");

  property p_wd_expire;
    $rose(rst_out.active_high) && !$past(cause) |->
      $past(wd_cnt_q) >= $past(wd_limit) && !$past(strobe_fall);
  endproperty
  a_wd_expire: assert property (p_wd_expire) // [R4]
    else $error("reset entered without cause or expiry");

  property p_wd_limit;
    pins_s.timeout_select == STRAP_LOW |-> wd_limit == WD_SHORT_TK;
  endproperty
  a_wd_limit: assert property (p_wd_limit) // [R9]
    else $error("short watchdog period not selected");

  property p_outputs_pair;
    rst_out.active_high == !rst_out.low_oe_n && !rst_out.low_o;
  endproperty
  a_outputs_pair: assert property (p_outputs_pair) // [R8]
    else $error("reset outputs disagree");

  property p_strobe_restart;
    strobe_fall |=> wd_cnt_q == CNT_ZERO;
  endproperty
  a_strobe_restart: assert property (p_strobe_restart) // [R10]
    else $error("strobe edge did not restart watchdog");

  property p_wd_idle_in_reset;
    rst_out.active_high |=> wd_cnt_q == CNT_ZERO;
  endproperty
  a_wd_idle_in_reset: assert property (p_wd_idle_in_reset) // [R11]
    else $error("watchdog counted during reset");

  property p_held_press;
    !pb_stable_q |=> hold_cnt_q == CNT_ZERO && rst_out.active_high;
  endproperty
  a_held_press: assert property (p_held_press) // [R12]
    else $error("hold time ran while button held");

  property p_tick_only;
    !tick && !cause && reset_on |=> $stable(hold_cnt_q);
  endproperty
  a_tick_only: assert property (p_tick_only) // [R13]
    else $error("hold counter moved without a tick");

endmodule

/* File: dv/cpu_model.sv */
// Behavioural processor that strobes the supervisor's watchdog.
// Assumes rst_active comes from the supervisor; it stays quiet while held in reset.
`timescale 1ns/1ps
module cpu_model #(
  parameter int unsigned GAP = 200
) (
  input  wire logic clk,
  input  wire logic rst_active,
  input  wire logic run,
  output logic      strobe_n
);
  int unsigned cnt_q = 0;

  // A processor in reset runs no code, so it cannot strobe
  always @(posedge clk) begin
    if (rst_active || !run) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
    end
  end

  // Low for 3 clocks: the supervisor needs 2 to see an edge
  assign strobe_n = !(run && !rst_active && cnt_q < 3);
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the reset supervisor with a strobing processor model.
// Assumes a 1 ms tick shortened to TL clocks; all times are checked in ticks.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
  import supervisor_pkg::*;
;
  localparam int unsigned TL    = 4;
  localparam int          LIMIT = 80000;
  logic       clk      = 1'b0;
  logic       arst_n   = 1'b0;
  logic       fail5    = 1'b0;
  logic       fail10   = 1'b0;
  logic       pb_n     = 1'b1;
  logic       band_sel = 1'b0;
  wd_strap_t  wd_sel   = STRAP_LOW;
  logic       run      = 1'b0;
  logic       strobe_n;
  logic       wire_n;
  pin_in_t    pins;
  reset_out_t rst_out;
  logic       reset_line_low;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  // Pull-up holds the open-drain wire high once released
  assign wire_n = (rst_out.low_oe_n === 1'b0) ? rst_out.low_o : 1'b1;
  assign pins   = '{fail5, fail10, pb_n, strobe_n, band_sel, wd_sel, wire_n};

  reset_supervisor_watchdog #(.TICK_LEN(TL)) u_reset_supervisor_watchdog (
    .clk            (clk),
    .arst_n         (arst_n),
    .pins           (pins),
    .rst_out        (rst_out),
    .reset_line_low (reset_line_low)
  );

  cpu_model #(.GAP(50 * TL)) u_cpu_model (
    .clk        (clk),
    .rst_active (rst_out.active_high),
    .run        (run),
    .strobe_n   (strobe_n)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded wait for the reset level; n reports cycles spent
  task automatic wait_level(input logic v, input int max, output int n);
    n = 0;
    while (rst_out.active_high !== v && n < max) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic t_powerup();
    int n;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    run    <= 1'b1;
    repeat (100 * TL) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b1)
    `CHK({rst_out.low_oe_n, rst_out.low_o}, 2'b00)
    `CHK(reset_line_low, 1'b1)
    wait_level(1'b0, 200 * TL, n);
    `CHK(n >= 150 * TL && n <= 152 * TL + 4, 1'b1)
    repeat (4) @(posedge clk);
    #1;
    `CHK({rst_out.low_oe_n, reset_line_low}, 2'b10)
    $display("test power-up done");
  endtask

  task automatic t_supply(input logic tv);
    int n;
    @(posedge clk);
    band_sel <= tv;
    fail5    <= tv;
    fail10   <= !tv;
    repeat (20) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b0)
    @(posedge clk);
    fail5  <= !tv;
    fail10 <= tv;
    repeat (3) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b1)
    repeat (50 * TL) @(posedge clk);
    fail5  <= 1'b0;
    fail10 <= 1'b0;
    #1;
    wait_level(1'b0, 300 * TL, n);
    `CHK(n >= 250 * TL && n <= 252 * TL + 4, 1'b1)
    $display("test supply tolerance %0h done", tv);
  endtask

  task automatic t_button();
    int n;
    @(posedge clk);
    pb_n <= 1'b0;
    repeat (10 * TL) @(posedge clk);
    pb_n <= 1'b1;
    repeat (40 * TL) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b0)
    @(posedge clk);
    pb_n <= 1'b0;
    repeat (30 * TL) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b1)
    @(posedge clk);
    pb_n <= 1'b1;
    #1;
    wait_level(1'b0, 300 * TL, n);
    `CHK(n >= 250 * TL && n <= 273 * TL + 4, 1'b1)
    $display("test pushbutton done");
  endtask

  // Reset pulled in mid-run must restart every counter, as at power-up
  task automatic t_midreset();
    int n;
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    `CHK({rst_out.active_high, rst_out.low_oe_n}, 2'b10)
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    wait_level(1'b0, 300 * TL, n);
    `CHK(n >= 251 * TL && n <= 251 * TL + 4, 1'b1)
    $display("test mid-run reset done");
  endtask

  task automatic t_wd(input wd_strap_t sel, input int lim);
    int n;
    @(posedge clk);
    wd_sel <= sel;
    repeat (2 * lim * TL) @(posedge clk);
    #1;
    `CHK(rst_out.active_high, 1'b0)
    @(posedge clk);
    run <= 1'b0;
    #1;
    wait_level(1'b1, (lim + 2) * TL, n);
    `CHK(rst_out.active_high, 1'b1)
    wait_level(1'b0, 260 * TL, n);
    `CHK(n >= 250 * TL && n <= 252 * TL + 4, 1'b1)
    wait_level(1'b1, (lim + 2) * TL, n);
    `CHK(n >= (lim - 1) * TL && n <= lim * TL + 4, 1'b1)
    @(posedge clk);
    run <= 1'b1;
    #1;
    wait_level(1'b0, 260 * TL, n);
    `CHK(rst_out.active_high, 1'b0)
    $display("test watchdog code %0h done", sel);
  endtask

  initial begin
    t_powerup();
    t_supply(1'b0);
    t_supply(1'b1);
    t_button();
    t_midreset();
    t_wd(STRAP_LOW, WD_SHORT_MS);
    t_wd(STRAP_OPEN, WD_MID_MS);
    t_wd(STRAP_HIGH, WD_LONG_MS);
    give_verdict();
  end
endmodule
